// file: rtl/sign_wait_core.sv
// execution of the sign-to-magnitude and wait instructions
`timescale 1ns/100ps
`include "sign_wait_regs.svh"
// What this block does
// - a conversion of a register whose top bit is clear leaves it unchanged.
// - with the top bit set, the conversion writes the two's complement of bits 14..0.
// - every conversion updates the sign flag from the operand's original top bit.
// - reset_select 0 XORs the sign into the flag, 1 overwrites it.
// - any register of the set may be converted; only that register, the sign flag and the program counter change.
// - a wait stops the program counter until an enabled row condition is true.
// - the lowest satisfied enabled row loads the program counter with that row's destination.
// - rows are held in a table written only by the wait-entry loading port.
// - the wait carries a five-bit row mask; unselected rows are ignored.
// - an all-zero mask enables no row, so the wait never ends.
// - mask bit 0 enables row 1, bit 1 row 2, bit 2 row 3.
// - mask bit 3 enables row 4 and bit 4 row 5.
module sign_wait_core #(
    parameter int ROWS = `WAIT_ROWS,
    parameter int PCW = `PC_WIDTH
)(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input sign_wait_pkg::exec_op_t instr_op,
    input sign_wait_pkg::instr_fields_t instr_fields,
    input wire logic [ROWS-1:0] row_condition,
    input sign_wait_pkg::wait_entry_t wait_entry,
    input wire logic reg_wr_en,
    input wire logic [`REG_SEL_WIDTH-1:0] reg_wr_sel,
    input wire logic [`DATA_WIDTH-1:0] reg_wr_data,
    input wire logic [`REG_SEL_WIDTH-1:0] reg_rd_sel,
    output logic [`DATA_WIDTH-1:0] reg_rd_data,
    output logic conv_sign,
    output logic [PCW-1:0] microcode_pc,
    output logic waiting
);
    logic [`DATA_WIDTH-1:0] alu_register_set [`REG_COUNT];
    logic [`DATA_WIDTH-1:0] first_operand;
    logic [`DATA_WIDTH-1:0] next_operand;
    logic [ROWS-1:0] wait_row_select;
    logic [ROWS-1:0] hit;
    logic [2:0] hit_row;
    logic hit_any;
    logic branch_pend;
    logic [PCW-1:0] row_dest;
    logic do_conv;
    logic do_wait;

    // lowest set bit index
    function automatic logic [2:0] lowest_row(input logic [ROWS-1:0] v);
        lowest_row = 3'h0;
        for (int i = ROWS - 1; i >= 0; i--)
            if (v[i])
                lowest_row = 3'(i);
    endfunction

    assign do_conv = instr_valid && (instr_op == sign_wait_pkg::op_toint);
    assign do_wait = instr_valid && (instr_op == sign_wait_pkg::op_wait) && !waiting;

    // ****************
    // sign conversion
    // ****************
    assign first_operand = alu_register_set[instr_fields.reg_sel];
    always_comb
    begin
        if (first_operand[`DATA_MSB])
            next_operand = {1'h0, 15'(-first_operand[`MAG_MSB:0])};
        else
            next_operand = first_operand;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < `REG_COUNT; i++)
                alu_register_set[i] <= `REG_RESET;
        end
        else if (do_conv)
            alu_register_set[instr_fields.reg_sel] <= next_operand;
        else if (reg_wr_en)
            alu_register_set[reg_wr_sel] <= reg_wr_data;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rd_data <= `REG_RESET;
        else
            reg_rd_data <= alu_register_set[reg_rd_sel];
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            conv_sign <= `CS_RESET;
        else if (do_conv)
        begin
            if (instr_fields.reset_select)
                conv_sign <= first_operand[`DATA_MSB];
            else
                conv_sign <= conv_sign ^ first_operand[`DATA_MSB];
        end
    end

    // ****************
    // wait and branch
    // ****************
    // row n+1 enabled by mask bit n
    generate
        for (genvar n = 0; n < ROWS; n++)
        begin : g_row
            // row n is the lowest satisfied enabled row
            sequence s_row_first;
                waiting && !branch_pend && wait_row_select[n] && row_condition[n]
                    && ((hit & ((ROWS'(1) << n) - ROWS'(1))) == '0);
            endsequence
            assign hit[n] = row_condition[n] & wait_row_select[n];
            a_row_branch: assert property (@(posedge mclk) disable iff (sys_rst)
                s_row_first |=> branch_pend ##1 microcode_pc == $past(u_table.mem[n]))
                else $error("row branch went to wrong destination");
            a_row_kept: assert property (@(posedge mclk) disable iff (sys_rst)
                !(wait_entry.load && (wait_entry.row == 3'(n)))
                |=> $stable(u_table.mem[n]))
                else $error("wait row changed without a load");
        end
    endgenerate
    assign hit_any = waiting && !branch_pend && (|hit);
    assign hit_row = lowest_row(hit);

    wait_table_mem #(.ROWS(ROWS), .PCW(PCW)) u_table (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .wr_en(wait_entry.load),
        .wr_row(wait_entry.row),
        .wr_dest(wait_entry.dest),
        .rd_row(hit_row),
        .rd_dest(row_dest)
    );

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            waiting <= 1'h0;
            wait_row_select <= `MASK_NONE;
            branch_pend <= 1'h0;
        end
        else if (branch_pend)
        begin
            branch_pend <= 1'h0;
            waiting <= 1'h0;
        end
        else if (hit_any)
            branch_pend <= 1'h1;
        else if (do_wait)
        begin
            waiting <= 1'h1;
            wait_row_select <= instr_fields.wait_row_select;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            microcode_pc <= `PC_RESET;
        else if (branch_pend)
            microcode_pc <= row_dest;
        else if (instr_valid && !waiting && !do_wait)
            microcode_pc <= microcode_pc + PCW'(1);
    end

    // ****************
    // checks
    // ****************
    // conversion, stall and branch checks
    sequence s_conv_pos;
        do_conv && !first_operand[`DATA_MSB];
    endsequence
    sequence s_conv_neg;
        do_conv && first_operand[`DATA_MSB];
    endsequence
    a_pos_unchanged: assert property (@(posedge mclk) disable iff (sys_rst)
        s_conv_pos
        |=> alu_register_set[$past(instr_fields.reg_sel)] == $past(first_operand))
        else $error("positive operand altered");
    a_neg_magnitude: assert property (@(posedge mclk) disable iff (sys_rst)
        s_conv_neg |=> alu_register_set[$past(instr_fields.reg_sel)]
            == {1'h0, 15'(~$past(first_operand[`MAG_MSB:0]) + 15'h1)})
        else $error("negative magnitude wrong");
    a_sign_replace: assert property (@(posedge mclk) disable iff (sys_rst)
        do_conv && instr_fields.reset_select |=> conv_sign == $past(first_operand[`DATA_MSB]))
        else $error("sign not overwritten");
    a_sign_xor: assert property (@(posedge mclk) disable iff (sys_rst)
        do_conv && !instr_fields.reset_select
        |=> conv_sign == ($past(conv_sign) ^ $past(first_operand[`DATA_MSB])))
        else $error("sign not accumulated");
    a_pc_stalled: assert property (@(posedge mclk) disable iff (sys_rst)
        waiting && !branch_pend |=> $stable(microcode_pc) || $past(branch_pend))
        else $error("pc moved while waiting");
    sequence s_hit;
        hit_any ##1 branch_pend;
    endsequence
    a_branch_dest: assert property (@(posedge mclk) disable iff (sys_rst)
        s_hit |=> microcode_pc == $past(row_dest) && !waiting)
        else $error("branch destination wrong");
    a_no_row_hang: assert property (@(posedge mclk) disable iff (sys_rst)
        waiting && wait_row_select == `MASK_NONE |=> waiting)
        else $error("empty mask wait ended");
    a_mask_ignored: assert property (@(posedge mclk) disable iff (sys_rst)
        waiting && !branch_pend && ((row_condition & wait_row_select) == '0) |=> !branch_pend)
        else $error("unselected row triggered branch");
    a_lowest_row: assert property (@(posedge mclk) disable iff (sys_rst)
        hit_any |-> hit[hit_row] && ((hit & ((ROWS'(1) << hit_row) - ROWS'(1))) == '0))
        else $error("not lowest satisfied row");
    // wait and sign-flag checks
    a_wait_enter: assert property (@(posedge mclk) disable iff (sys_rst)
        do_wait |=> waiting && (wait_row_select == $past(instr_fields.wait_row_select)))
        else $error("wait not entered with its mask");
    a_wait_holds: assert property (@(posedge mclk) disable iff (sys_rst)
        waiting && !branch_pend && !hit_any |=> waiting && !branch_pend)
        else $error("wait ended with no satisfied row");
    a_pc_step: assert property (@(posedge mclk) disable iff (sys_rst)
        instr_valid && !waiting && (instr_op != sign_wait_pkg::op_wait)
        |=> microcode_pc == $past(microcode_pc) + PCW'(1))
        else $error("pc did not advance outside a wait");
    a_sign_only_conv: assert property (@(posedge mclk) disable iff (sys_rst)
        !do_conv |=> $stable(conv_sign))
        else $error("sign flag changed without a conversion");
endmodule // sign_wait_core

// file: rtl/sign_wait_pkg.sv
// shared types for the sign-convert and wait execution block
package sign_wait_pkg;
    typedef enum logic [1:0] {op_none, op_toint, op_wait} exec_op_t;
    typedef struct packed {
        logic [3:0] reg_sel;
        logic reset_select;
        logic [4:0] wait_row_select;
    } instr_fields_t;
    typedef struct packed {
        logic load;
        logic [2:0] row;
        logic [9:0] dest;
    } wait_entry_t;
endpackage

// file: rtl/sign_wait_regs.svh
// constants for the sign-convert and wait execution block
`ifndef SIGN_WAIT_REGS_SVH
`define SIGN_WAIT_REGS_SVH
`define DATA_WIDTH 16
`define DATA_MSB 15
`define MAG_MSB 14
`define PC_WIDTH 10
`define WAIT_ROWS 5
`define REG_SEL_WIDTH 4
`define REG_COUNT 16
`define MASK_NONE 5'h00
`define CS_RESET 1'h0
`define PC_RESET 10'h000
`define REG_RESET 16'h0000
`endif

// file: rtl/wait_table_mem.sv
// wait-table row store with registered destination readout
`timescale 1ns/100ps
`include "sign_wait_regs.svh"
module wait_table_mem #(
    parameter int ROWS = `WAIT_ROWS,
    parameter int PCW = `PC_WIDTH
)(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [2:0] wr_row,
    input wire logic [PCW-1:0] wr_dest,
    input wire logic [2:0] rd_row,
    output logic [PCW-1:0] rd_dest
);
    logic [PCW-1:0] mem [ROWS];

    // ****************
    // storage
    // ****************
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < ROWS; i++)
                mem[i] <= '0;
        end
        else if (wr_en && (int'(wr_row) < ROWS))
            mem[wr_row] <= wr_dest;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            rd_dest <= '0;
        else if (int'(rd_row) < ROWS)
            rd_dest <= mem[rd_row];
        else
            rd_dest <= '0;
    end
endmodule // wait_table_mem

// file: tb/tb.sv
// self-checking bench for the sign-convert and wait block
`timescale 1ns/100ps
module tb;
    logic mclk;
    logic sys_rst;
    logic instr_valid;
    sign_wait_pkg::exec_op_t instr_op;
    sign_wait_pkg::instr_fields_t instr_fields;
    logic [4:0] row_condition;
    sign_wait_pkg::wait_entry_t wait_entry;
    logic reg_wr_en;
    logic [3:0] reg_wr_sel;
    logic [15:0] reg_wr_data;
    logic [3:0] reg_rd_sel;
    logic [15:0] reg_rd_data;
    logic conv_sign;
    logic [9:0] microcode_pc;
    logic waiting;
    int fail_count;
    int check_count;
    logic cs;
    logic [9:0] pc;
    logic [15:0] vals [5] = '{16'h1234, 16'h8001, 16'hffff, 16'h8000, 16'h7fff};
    sign_wait_core dut (.mclk(mclk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_fields(instr_fields), .row_condition(row_condition),
        .wait_entry(wait_entry), .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel),
        .reg_wr_data(reg_wr_data), .reg_rd_sel(reg_rd_sel), .reg_rd_data(reg_rd_data),
        .conv_sign(conv_sign), .microcode_pc(microcode_pc), .waiting(waiting));
    // ****************
    // access tasks
    // ****************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic issue(input sign_wait_pkg::exec_op_t op, input logic [3:0] r,
        input logic rs, input logic [4:0] m);
        @(negedge mclk);
        instr_valid = 1'h1;
        instr_op = op;
        instr_fields = {r, rs, m};
        @(negedge mclk);
        instr_valid = 1'h0;
    endtask
    task automatic conv(input logic [3:0] r, input logic [15:0] d, input logic rs);
        @(negedge mclk);
        reg_wr_en = 1'h1;
        reg_wr_sel = r;
        reg_wr_data = d;
        @(negedge mclk);
        reg_wr_en = 1'h0;
        issue(sign_wait_pkg::op_toint, r, rs, 5'h00);
        reg_rd_sel = r;
        repeat (2) @(negedge mclk);
        cs = rs ? d[15] : cs ^ d[15];
        pc = pc + 10'h001;
        check(reg_rd_data, d[15] ? {1'h0, 15'(~d[14:0] + 15'h1)} : d);
        check(16'(conv_sign), 16'(cs));
        check(16'(microcode_pc), 16'(pc));
    endtask
    task automatic do_wait(input logic [4:0] m, input logic [4:0] c, input logic [9:0] d);
        int k;
        issue(sign_wait_pkg::op_wait, 4'h0, 1'h0, m);
        row_condition = ~m;
        repeat (4) @(negedge mclk);
        check(16'(waiting), 16'h0001);
        check(16'(microcode_pc), 16'(pc));
        row_condition = c;
        k = 0;
        while (waiting !== 1'h0 && k < 20)
        begin
            @(negedge mclk);
            k++;
        end
        row_condition = 5'h00;
        if (waiting !== 1'h0)
        begin
            fail_count++;
            $display("[FAIL] %0t wait never ended", $time);
            results();
        end
        else
        begin
            pc = d;
            check(16'(microcode_pc), 16'(d));
        end
    endtask
    initial
    begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    // ****************
    // main sequence
    // ****************
    initial
    begin
        sys_rst = 1'h1;
        instr_valid = 1'h0;
        instr_op = sign_wait_pkg::op_none;
        instr_fields = '0;
        row_condition = 5'h00;
        wait_entry = '0;
        reg_wr_en = 1'h0;
        reg_wr_sel = 4'h0;
        reg_wr_data = 16'h0000;
        reg_rd_sel = 4'h0;
        fail_count = 0;
        check_count = 0;
        cs = 1'h0;
        pc = 10'h000;
        repeat (6) @(negedge mclk);
        sys_rst = 1'h0;
        check(16'({waiting, conv_sign, microcode_pc}), 16'h0000);
        for (int i = 0; i < 5; i++)
            conv(4'(i * 3), vals[i], i[0] ^ i[1]);
        reg_rd_sel = 4'h3;
        repeat (2) @(negedge mclk);
        check(reg_rd_data, 16'h7fff);
        for (int i = 0; i < 5; i++)
        begin
            @(negedge mclk);
            wait_entry = {1'h1, 3'(i), 10'h200 + 10'(i)};
        end
        @(negedge mclk);
        wait_entry = {1'h1, 3'h5, 10'h3ff};
        @(negedge mclk);
        wait_entry = '0;
        for (int i = 0; i < 5; i++)
            do_wait(5'h01 << i, 5'h1f, 10'h200 + 10'(i));
        do_wait(5'h03, 5'h02, 10'h201);
        do_wait(5'h16, 5'h1f, 10'h201);
        issue(sign_wait_pkg::op_wait, 4'h0, 1'h0, 5'h00);
        row_condition = 5'h1f;
        repeat (8) @(negedge mclk);
        check(16'({waiting, microcode_pc}), 16'({1'h1, pc}));
        sys_rst = 1'h1;
        @(negedge mclk);
        check(16'({waiting, conv_sign, microcode_pc}), 16'h0000);
        sys_rst = 1'h0;
        row_condition = 5'h00;
        cs = 1'h0;
        pc = 10'h000;
        conv(4'hf, 16'h8001, 1'h0);
        results();
    end
endmodule // tb
